//--- switch_channel_mode_control.sv
// mode control, serial port and per-channel on/off command of a dual high side switch
// Summary of operation
// - serial output driven only while chip select is low, else released
// - serial output bit changes only on serial clock rising edges
// - shift out one of thirteen readback registers or the previous word
// - readback works only while the interface supply is present
// - fail-safe flag pin pulled low on lost communication or supply failure
// - four modes sleep, normal, fail-safe, fault; two independent channels
// - normal mode flag reads one; reached by direct input or reset input wake
// - normal only when awake and neither fail-safe nor fault holds
// - wake event resets registers, enters normal, ready after 50 us
// - per-channel pulse width, configuration and overcurrent registers
// - normal mode drives channels from direct input or pwm module
// - pwm up to 1 kHz from internal or external clock
// - direct mode on command follows the direct input level
// - internal clock select bit one times channel from internal clock
// - external clock mode takes period from external pwm clock
// - target on from enabled direct input, or on bit without pwm
// - with pwm, target on is on bit gated by duty waveform
// - status register shows on state and fault per channel
// - eight distinct fault types kept per channel
// - watchdog bit must toggle within 310 ms unless disabled, else fail-safe
// - input activity flag drops after 250 ms idle; sleep when all low
// - fail-safe: direct control only, registers blocked and reset, faults cleared
// - enabled fault in normal or fail-safe enters fault mode
`timescale 1ns/1ps
`default_nettype none
module switch_channel_mode_control
  import switch_ctl_pkg::*;
#(
  parameter int WDTO_CYCLES  = WDTO_CYC,
  parameter int IN_TO_CYCLES = IN_TO_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       reset_n_input,
  input  wire logic [1:0] dir_in,
  input  wire logic       ext_pwm_clk,
  input  wire logic       vdd_ok,
  input  wire logic [7:0] fault_a,
  input  wire logic [7:0] fault_b,
  input  wire logic       chip_select_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_si,
  output logic            spi_so,
  output logic            spi_so_oe,
  output logic            failsafe_flag_n,
  output logic            failsafe_flag_n_oe,
  output logic            switch_output_a,
  output logic            switch_output_b,
  output mode_e           mode,
  output logic            normal_mode_flag,
  output logic            func_ready
);

  logic [1:0] rst_sync;
  logic       rst_sync_n;
  state_s     state_reg;
  state_s     state_next;

  function automatic logic [9:0] div_limit(input logic [1:0] pr);
    div_limit = 10'(INT_DIV_CYC * (int'(pr) + 1) - 1);
  endfunction

  function automatic logic mode_fault(input logic [7:0] f);
    mode_fault = |(f & MODE_FLT_MASK);
  endfunction

  // back to defaults, faults untouched
  function automatic state_s regs_default(input state_s s);
    state_s r;
    r = s;
    for (int c = 0; c < 2; c++) begin
      r.ch[c].pw  = REG_RST;
      r.ch[c].cfg = REG_RST;
      r.ch[c].oc  = REG_RST;
    end
    r.gcfg = REG_RST;
    r.sel  = SO_STATUS;
    return r;
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync[1];

  logic [7:0]  flt_in [2];
  logic        wake;
  logic        fault_cond;
  logic        fs_cond;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        ext_rise;
  logic        tick;
  logic        wave;
  logic        din_on;
  logic [3:0]  waddr;
  logic [8:0]  wdata;
  logic [8:0]  so_val;
  logic [8:0]  status_val;
  mode_e       mode_new;

  always_comb begin
    state_next = state_reg;
    flt_in[0]  = fault_a;
    flt_in[1]  = fault_b;
    sclk_rise  = spi_sclk & ~state_reg.sclk_prev;
    sclk_fall  = ~spi_sclk & state_reg.sclk_prev;
    cs_fall    = ~chip_select_n & state_reg.cs_prev;
    cs_rise    = chip_select_n & ~state_reg.cs_prev;
    ext_rise   = ext_pwm_clk & ~state_reg.ext_prev;
    waddr      = state_reg.rx[ADDR_HI:ADDR_LO];
    wdata      = state_reg.rx[8:0];
    tick       = 1'b0;
    wave       = 1'b0;
    din_on     = 1'b0;
    state_next.sclk_prev = spi_sclk;
    state_next.cs_prev   = chip_select_n;
    state_next.ext_prev  = ext_pwm_clk;
    state_next.rst_prev  = reset_n_input;

    // input activity; a held-high input counts as active
    for (int c = 0; c < 2; c++) begin
      state_next.ch[c].in_prev = dir_in[c];
      if (dir_in[c]) begin
        state_next.ch[c].in_on  = 1'b1;
        state_next.ch[c].in_tmr = '0;
      end else if (state_reg.ch[c].in_on) begin
        if (state_reg.ch[c].in_tmr >= 23'(IN_TO_CYCLES - 1)) begin
          state_next.ch[c].in_on = 1'b0;
        end else begin
          state_next.ch[c].in_tmr = state_reg.ch[c].in_tmr + 23'd1;
        end
      end
    end
    wake = reset_n_input | state_reg.ch[0].in_on | state_reg.ch[1].in_on;
    state_next.wake_prev = wake;
    // a wake starts clean, else a stale fail-safe cause would block normal mode
    if (wake & ~state_reg.wake_prev) begin
      state_next.vdd_lost = 1'b0;
      state_next.wd_to    = 1'b0;
      state_next.fs_armed = 1'b0;
    end

    // supply loss only counts after the supply was seen once
    if (vdd_ok) begin
      state_next.vdd_seen = 1'b1;
    end
    if (state_reg.vdd_seen & ~vdd_ok & state_reg.gcfg[GCFG_VDD_EN]) begin
      state_next.vdd_lost = 1'b1;
    end

    // watchdog restarts on every reset input rising edge
    if (reset_n_input & ~state_reg.rst_prev) begin
      state_next.wd_tmr = '0;
      state_next.wd_to  = 1'b0;
    end else if (reset_n_input & vdd_ok & ~state_reg.gcfg[GCFG_WATCHDOG_DISABLE_BIT] & state_reg.mode != MODE_SLEEP) begin
      if (state_reg.wd_tmr >= 23'(WDTO_CYCLES - 1)) begin
        state_next.wd_to = 1'b1;
      end else begin
        state_next.wd_tmr = state_reg.wd_tmr + 23'd1;
      end
    end

    // serial receive on falling clock edges
    if (sclk_fall & ~chip_select_n) begin
      state_next.rx = {state_reg.rx[WORD_BITS-2:0], spi_si};
      if (state_reg.rx_cnt < WORD_BITS_5) begin
        state_next.rx_cnt = state_reg.rx_cnt + 5'd1;
      end
    end

    // status word: on states, fault summaries, mode
    status_val = {2'b00, |state_reg.ch[1].flt, |state_reg.ch[0].flt,
                  state_reg.ch[1].hson, state_reg.ch[0].hson,
                  state_reg.mode == MODE_NORMAL, state_reg.mode};
    case (state_reg.sel)
      SO_STATUS:    so_val = status_val;
      SO_FLT_A:     so_val = {1'b0, state_reg.ch[0].flt};
      SO_FLT_A + 4'h1: so_val = {1'b0, state_reg.ch[1].flt};
      SO_PW_A:         so_val = state_reg.ch[0].pw;
      SO_PW_A + 4'h1:  so_val = state_reg.ch[1].pw;
      SO_CFG_A:        so_val = state_reg.ch[0].cfg;
      SO_CFG_A + 4'h1: so_val = state_reg.ch[1].cfg;
      SO_OC_A:         so_val = state_reg.ch[0].oc;
      SO_OC_A + 4'h1:  so_val = state_reg.ch[1].oc;
      SO_GCFG:         so_val = state_reg.gcfg;
      SO_WAKE:         so_val = {4'h0, state_reg.ready, state_reg.wd_to, state_reg.vdd_lost,
                                 state_reg.ch[1].in_on, state_reg.ch[0].in_on};
      SO_RAW_A:        so_val = {1'b0, fault_a};
      SO_RAW_A + 4'h1: so_val = {1'b0, fault_b};
      default:      so_val = 9'h000;
    endcase

    // load readback at frame start; reading a fault register clears it
    if (cs_fall) begin
      state_next.rx_cnt = '0;
      if (state_reg.sel == SO_PREV) begin
        state_next.tx = state_reg.prev_word;
      end else begin
        state_next.tx = {3'b000, state_reg.sel, so_val};
      end
      for (int c = 0; c < 2; c++) begin
        if (state_reg.sel == SO_FLT_A + 4'(c)) begin
          state_next.ch[c].flt = '0;
        end
      end
    end else if (sclk_rise & ~chip_select_n) begin
      state_next.so_bit = state_reg.tx[WORD_BITS-1];
      state_next.tx     = {state_reg.tx[WORD_BITS-2:0], 1'b0};
    end

    // complete word taken at chip select release
    if (cs_rise & (state_reg.rx_cnt == WORD_BITS_5) & reset_n_input) begin
      state_next.prev_word = state_reg.rx;
      state_next.wd_last   = state_reg.rx[WD_BIT];
      if (state_reg.rx[WD_BIT] != state_reg.wd_last) begin
        state_next.wd_tmr = '0;
      end
      if (state_reg.mode == MODE_FAILSAFE) begin
        // exit needs a word with the toggle bit set; after a supply loss, a second word in time too
        if (state_reg.fs_armed & ~state_reg.wd_to & vdd_ok) begin
          state_next.fs_armed = 1'b0;
          state_next.vdd_lost = 1'b0;
        end else if (state_reg.rx[WD_BIT]) begin
          state_next.fs_armed = 1'b1;
          state_next.wd_to    = 1'b0;
          state_next.wd_tmr   = '0;
        end
      end else if (state_reg.mode != MODE_SLEEP) begin
        case (waddr)
          ADDR_SO_SEL:    state_next.sel = wdata[3:0];
          ADDR_PW_A:      state_next.ch[0].pw = wdata;
          ADDR_PW_A + 4'h1:  state_next.ch[1].pw = wdata;
          ADDR_CFG_A:        state_next.ch[0].cfg = wdata;
          ADDR_CFG_A + 4'h1: state_next.ch[1].cfg = wdata;
          ADDR_OC_A:         state_next.ch[0].oc = wdata;
          ADDR_OC_A + 4'h1:  state_next.ch[1].oc = wdata;
          ADDR_GCFG:      state_next.gcfg = wdata;
          default:        state_next.sel = state_reg.sel;
        endcase
      end
    end

    // faults stick until read; a new fault wins over the clear
    for (int c = 0; c < 2; c++) begin
      state_next.ch[c].flt = state_next.ch[c].flt | flt_in[c];
    end
    fault_cond = mode_fault(fault_a) | mode_fault(fault_b);
    fs_cond = state_next.vdd_lost | (state_next.wd_to & ~state_next.gcfg[GCFG_WATCHDOG_DISABLE_BIT]);
    state_next.fs_ind = fs_cond & wake;

    if (!wake) begin
      mode_new = MODE_SLEEP;
    end else if (fault_cond) begin
      mode_new = MODE_FAULT;
    end else if (fs_cond) begin
      mode_new = MODE_FAILSAFE;
    end else begin
      mode_new = MODE_NORMAL;
    end
    state_next.mode = mode_new;

    if (wake & ~state_reg.wake_prev) begin
      state_next         = regs_default(state_next);
      state_next.rdy_tmr = '0;
      state_next.ready   = 1'b0;
      state_next.wd_tmr  = '0;
    end else if (mode_new == MODE_FAILSAFE && state_reg.mode != MODE_FAILSAFE) begin
      state_next = regs_default(state_next);
      for (int c = 0; c < 2; c++) begin
        state_next.ch[c].flt = flt_in[c];
      end
    end else if (mode_new == MODE_NORMAL && state_reg.mode == MODE_FAILSAFE) begin
      state_next = regs_default(state_next);
    end else if (!state_reg.ready && wake) begin
      if (state_reg.rdy_tmr >= 11'(READY_CYC - 1)) begin
        state_next.ready = 1'b1;
      end else begin
        state_next.rdy_tmr = state_reg.rdy_tmr + 11'd1;
      end
    end

    // pwm phase per channel, internal divider or external edges
    for (int c = 0; c < 2; c++) begin
      if (state_reg.ch[c].cfg[CFG_CLK_INT]) begin
        tick = state_reg.ch[c].div >= div_limit(state_reg.ch[c].cfg[CFG_PR_LO+:2]);
        state_next.ch[c].div = tick ? 10'd0 : state_reg.ch[c].div + 10'd1;
      end else begin
        tick = ext_rise;
        state_next.ch[c].div = '0;
      end
      if (tick) begin
        state_next.ch[c].phase = state_reg.ch[c].phase + 8'd1;
      end
      // turn-on delay shifts the duty window within the period
      wave = 8'(state_reg.ch[c].phase - {state_reg.ch[c].cfg[CFG_DLY_LO+:3], 5'd0})
             < state_reg.ch[c].pw[7:0];
      din_on = dir_in[c] & ~state_reg.ch[c].cfg[CFG_DIR_DIS];
      case (mode_new)
        MODE_NORMAL: state_next.ch[c].hson = state_reg.ready & (din_on | (state_reg.ch[c].pw[PW_ON_BIT] &
                       (state_reg.ch[c].cfg[CFG_PWM_EN] ? wave : 1'b1)));
        MODE_FAILSAFE: state_next.ch[c].hson = dir_in[c];
        default: state_next.ch[c].hson = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // no interface supply, no readback
  assign spi_so             = state_reg.so_bit;
  assign spi_so_oe          = ~chip_select_n & vdd_ok;
  assign failsafe_flag_n    = 1'b0;
  assign failsafe_flag_n_oe = state_reg.fs_ind;
  assign switch_output_a    = state_reg.ch[0].hson;
  assign switch_output_b    = state_reg.ch[1].hson;
  assign mode               = state_reg.mode;
  assign normal_mode_flag   = state_reg.mode == MODE_NORMAL;
  assign func_ready         = state_reg.ready;

endmodule // switch_channel_mode_control
`default_nettype wire

//--- switch_channel_mode_control_tb_top.sv
// self-checking bench for the channel mode controller
`timescale 1ns/1ps
`default_nettype none
module switch_channel_mode_control_tb_top
  import switch_ctl_pkg::*;
;
  localparam int WD_SIM = 3000;
  localparam int IN_SIM = 100;
  typedef struct {int id; logic [15:0] v;} note_s;
  logic ref_clk = 1'b0, rst_n = 1'b0, reset_n_input = 1'b0, ext_pwm_clk = 1'b0, vdd_ok = 1'b1;
  logic [1:0] dir_in = 2'b00;
  logic [7:0] fault_a = 8'h00, fault_b = 8'h00;
  logic chip_select_n, spi_sclk, spi_si, spi_so, spi_so_oe, failsafe_flag_n, failsafe_flag_n_oe;
  logic switch_output_a, switch_output_b, normal_mode_flag, func_ready, wd, duty_ok;
  mode_e mode;
  wire so_pin = spi_so_oe ? spi_so : 1'bz;
  wire failsafe_flag_n_pin = failsafe_flag_n_oe ? failsafe_flag_n : 1'b1;
  logic [15:0] rd, cur_word, last_word, s;
  int seed, hi, err_total = 0, samples_checked = 0;
  note_s q[$];
  note_s e;
  event ev;
  string nm[7] = '{"mode", "outputs", "readback", "fail_flag", "ready", "so_enable", "duty"};

  always #20 ref_clk = ~ref_clk;

  switch_channel_mode_control #(.WDTO_CYCLES(WD_SIM), .IN_TO_CYCLES(IN_SIM)) i_switch_channel_mode_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .reset_n_input(reset_n_input), .dir_in(dir_in),
    .ext_pwm_clk(ext_pwm_clk), .vdd_ok(vdd_ok), .fault_a(fault_a), .fault_b(fault_b),
    .chip_select_n(chip_select_n), .spi_sclk(spi_sclk), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .failsafe_flag_n(failsafe_flag_n), .failsafe_flag_n_oe(failsafe_flag_n_oe),
    .switch_output_a(switch_output_a), .switch_output_b(switch_output_b), .mode(mode),
    .normal_mode_flag(normal_mode_flag), .func_ready(func_ready));

  switch_host_model i_switch_host_model (.ref_clk(ref_clk), .so_pin(so_pin),
    .chip_select_n(chip_select_n), .spi_sclk(spi_sclk), .spi_si(spi_si));

  function automatic logic [15:0] seen(input int id);
    case (id)
      0: return {14'h0000, mode};
      1: return {14'h0000, switch_output_b, switch_output_a};
      2: return rd;
      3: return {15'h0000, failsafe_flag_n_pin};
      4: return {15'h0000, func_ready};
      5: return {15'h0000, spi_so_oe};
      default: return {15'h0000, duty_ok};
    endcase
  endfunction

  task automatic chk(input int id, input logic [15:0] v);
    q.push_back('{id, v});
    ->ev;
  endtask

  task automatic cm(input mode_e m);
    chk(0, {14'h0000, m});
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    wd = ~wd;
    last_word = cur_word;
    cur_word = {wd, 2'b00, a, d};
    i_switch_host_model.xfer(cur_word, rd);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(ev) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      s = seen(e.id);
      samples_checked++;
      if (s !== e.v) begin
        err_total++;
        $display("Error %s expected %h seen %h", nm[e.id], e.v, s);
      end
    end
  end

  initial begin
    #3600000;
    err_total++;
    end_sim();
  end

  initial begin
    seed = 95239;
    wd = 1'b0;
    repeat (4) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    tk(3);
    cm(MODE_SLEEP);
    chk(5, 16'h0000);
    chk(3, 16'h0001);
    reset_n_input = 1'b1;
    tk(4);
    cm(MODE_NORMAL);
    tk(1190);
    chk(4, 16'h0000);
    tk(70);
    chk(4, 16'h0001);
    wr(ADDR_PW_A, 9'h100);
    wr(ADDR_SO_SEL, {5'h00, SO_PW_A});
    wr(ADDR_CFG_A, 9'h000);
    chk(2, {3'b000, SO_PW_A, 9'h100});
    wr(ADDR_SO_SEL, {5'h00, SO_PREV});
    wr(ADDR_GCFG, 9'h001);
    chk(2, last_word);
    for (int i = 0; i < 8; i++) begin
      dir_in = 2'($random(seed));
      tk(3);
      chk(1, {14'h0000, dir_in[1], 1'b1});
    end
    wr(ADDR_CFG_A + 4'h1, 9'h004);
    dir_in = 2'b10;
    tk(3);
    chk(1, 16'h0001);
    dir_in = 2'b00;
    // external clock first, then internal; one full pwm period each
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_PW_A, 9'h180);
      wr(ADDR_CFG_A, k ? 9'h003 : 9'h001);
      hi = 0;
      for (int c = 0; c < 25088; c++) begin
        if (c % 49 == 0) ext_pwm_clk = ~ext_pwm_clk;
        tk(1);
        hi += int'(switch_output_a);
      end
      duty_ok = hi > 11000 && hi < 14000;
      chk(6, 16'h0001);
    end
    wr(ADDR_SO_SEL, {5'h00, SO_FLT_A});
    for (int k = 0; k < 16; k++) begin
      {fault_b, fault_a} = 16'h0001 << k;
      tk(4);
      cm(k % 8 > 1 ? MODE_FAULT : MODE_NORMAL);
      {fault_b, fault_a} = 16'h0000;
      tk(4);
    end
    wr(ADDR_GCFG, 9'h001);
    chk(2, {3'b000, SO_FLT_A, 9'h0ff});
    wr(ADDR_GCFG, 9'h000);
    dir_in = 2'b10;
    tk(WD_SIM + 20);
    cm(MODE_FAILSAFE);
    chk(3, 16'h0000);
    chk(1, 16'h0002);
    wd = 1'b0;
    wr(ADDR_GCFG, 9'h001);
    wr(ADDR_GCFG, 9'h001);
    tk(2);
    cm(MODE_NORMAL);
    chk(3, 16'h0001);
    wr(ADDR_SO_SEL, {5'h00, SO_PW_A});
    wr(ADDR_GCFG, 9'h003);
    chk(2, {3'b000, SO_PW_A, REG_RST});
    vdd_ok = 1'b0;
    tk(4);
    cm(MODE_FAILSAFE);
    chk(3, 16'h0000);
    vdd_ok = 1'b1;
    reset_n_input = 1'b0;
    dir_in = 2'b00;
    tk(IN_SIM + 20);
    cm(MODE_SLEEP);
    chk(1, 16'h0000);
    dir_in = 2'b01;
    tk(4);
    cm(MODE_NORMAL);
    tk(1);
    end_sim();
  end
endmodule // switch_channel_mode_control_tb_top
`default_nettype wire

//--- switch_ctl_pkg.sv
// constants and carrier types shared by the channel mode controller
package switch_ctl_pkg;
  localparam int CLK_KHZ       = 25000;
  localparam int WDTO_MS       = 310;
  localparam int WDTO_CYC      = WDTO_MS * CLK_KHZ;
  localparam int IN_TO_MS      = 250;
  localparam int IN_TO_CYC     = IN_TO_MS * CLK_KHZ;
  localparam int READY_US      = 50;
  localparam int READY_CYC     = READY_US * CLK_KHZ / 1000;
  localparam int PWM_MAX_HZ    = 1000;
  localparam int PWM_STEPS     = 256;
  localparam int INT_DIV_CYC   = (CLK_KHZ * 1000 + PWM_MAX_HZ * PWM_STEPS - 1) / (PWM_MAX_HZ * PWM_STEPS);
  localparam int NUM_SO_REGS   = 13;
  // serial word layout
  localparam int WORD_BITS     = 16;
  localparam int WD_BIT        = 15;
  localparam int ADDR_HI       = 12;
  localparam int ADDR_LO       = 9;
  localparam logic [4:0] WORD_BITS_5 = 5'd16;
  // write addresses
  localparam logic [3:0] ADDR_SO_SEL = 4'h0;
  localparam logic [3:0] ADDR_PW_A   = 4'h1;
  localparam logic [3:0] ADDR_CFG_A  = 4'h3;
  localparam logic [3:0] ADDR_OC_A   = 4'h5;
  localparam logic [3:0] ADDR_GCFG   = 4'h7;
  // readback selections
  localparam logic [3:0] SO_STATUS   = 4'h0;
  localparam logic [3:0] SO_FLT_A    = 4'h1;
  localparam logic [3:0] SO_PW_A     = 4'h3;
  localparam logic [3:0] SO_CFG_A    = 4'h5;
  localparam logic [3:0] SO_OC_A     = 4'h7;
  localparam logic [3:0] SO_GCFG     = 4'h9;
  localparam logic [3:0] SO_WAKE     = 4'ha;
  localparam logic [3:0] SO_RAW_A    = 4'hb;
  localparam logic [3:0] SO_PREV     = 4'hd;
  // field positions
  localparam int PW_ON_BIT     = 8;
  localparam int CFG_PWM_EN    = 0;
  localparam int CFG_CLK_INT   = 1;
  localparam int CFG_DIR_DIS   = 2;
  localparam int CFG_PR_LO     = 3;
  localparam int CFG_DLY_LO    = 5;
  localparam int GCFG_WATCHDOG_DISABLE_BIT   = 0;
  localparam int GCFG_VDD_EN   = 1;
  localparam logic [8:0] REG_RST = 9'h000;
  // fault vector bit order
  localparam int FLT_OPEN_LOAD = 0;
  localparam int FLT_SHORT_BAT = 1;
  localparam int FLT_SEVERE    = 2;
  localparam int FLT_OVERCUR   = 3;
  localparam int FLT_OVERTEMP  = 4;
  localparam int FLT_CLK_FAIL  = 5;
  localparam int FLT_UNDERV    = 6;
  localparam int FLT_OVERV     = 7;
  localparam logic [7:0] MODE_FLT_MASK = 8'hfc;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE, MODE_FAULT} mode_e;

  typedef struct packed {
    logic [8:0]  pw;
    logic [8:0]  cfg;
    logic [8:0]  oc;
    logic [7:0]  flt;
    logic [7:0]  phase;
    logic [9:0]  div;
    logic        in_on;
    logic        in_prev;
    logic [22:0] in_tmr;
    logic        hson;
  } chan_s;

  typedef struct packed {
    mode_e       mode;
    chan_s [1:0] ch;
    logic [8:0]  gcfg;
    logic [3:0]  sel;
    logic [15:0] rx;
    logic [4:0]  rx_cnt;
    logic [15:0] tx;
    logic [15:0] prev_word;
    logic        so_bit;
    logic        sclk_prev;
    logic        cs_prev;
    logic        ext_prev;
    logic        rst_prev;
    logic        wake_prev;
    logic [22:0] wd_tmr;
    logic        wd_last;
    logic        wd_to;
    logic        vdd_seen;
    logic        vdd_lost;
    logic        fs_armed;
    logic        fs_ind;
    logic [10:0] rdy_tmr;
    logic        ready;
  } state_s;
endpackage

//--- switch_ctl_sva.sv
// concurrent checks on the ports of the channel mode controller
`timescale 1ns/1ps
`default_nettype none
module switch_ctl_sva
  import switch_ctl_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       reset_n_input,
  input wire logic [1:0] dir_in,
  input wire logic [7:0] fault_a,
  input wire logic [7:0] fault_b,
  input wire logic       vdd_ok,
  input wire logic       chip_select_n,
  input wire logic       spi_sclk,
  input wire logic       spi_so,
  input wire logic       spi_so_oe,
  input wire logic       failsafe_flag_n,
  input wire logic       failsafe_flag_n_oe,
  input wire logic       switch_output_a,
  input wire logic       switch_output_b,
  input wire mode_e      mode,
  input wire logic       normal_mode_flag,
  input wire logic       func_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // cycles awake without ready; cleared in sleep so each wake is timed afresh
  logic [11:0] rdy_cnt_reg;
  logic [11:0] rdy_cnt_next;
  always_comb rdy_cnt_next = (func_ready || mode == MODE_SLEEP) ? 12'h000 : rdy_cnt_reg + 12'h001;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rdy_cnt_reg <= 12'h000;
    else rdy_cnt_reg <= rdy_cnt_next;
  end

  so_enable_a: assert property (spi_so_oe == (!chip_select_n && vdd_ok))
    else $error("serial out enable wrong");
  so_edge_a: assert property ($changed(spi_so) |-> $past(spi_sclk) && !$past(chip_select_n))
    else $error("serial out moved without a clock rise");
  nm_flag_a: assert property (normal_mode_flag == (mode == MODE_NORMAL))
    else $error("normal flag disagrees with mode");
  fs_flag_a: assert property ((mode == MODE_FAILSAFE) [*2] |-> failsafe_flag_n_oe && !failsafe_flag_n)
    else $error("fail-safe flag not pulled low");
  fault_entry_a: assert property ((|((fault_a | fault_b) & MODE_FLT_MASK)) && reset_n_input
    && $past(reset_n_input, 2) && mode != MODE_SLEEP |-> ##[1:2] mode == MODE_FAULT)
    else $error("fault mode not entered");
  sleep_hold_a: assert property (!reset_n_input && !$past(reset_n_input) && dir_in == 2'b00
    && $past(dir_in) == 2'b00 && mode == MODE_SLEEP |=> mode == MODE_SLEEP)
    else $error("left sleep without wake");
  off_outputs_a: assert property ((mode == MODE_FAULT || mode == MODE_SLEEP) [*2]
    |-> !switch_output_a && !switch_output_b)
    else $error("channel on in sleep or fault");
  fs_direct_a: assert property (mode == MODE_FAILSAFE && $past(mode) == MODE_FAILSAFE
    && $past(dir_in) == $past(dir_in, 2) |-> {switch_output_b, switch_output_a} == $past(dir_in))
    else $error("fail-safe outputs not following direct inputs");
  ready_time_a: assert property ($rose(func_ready) |-> rdy_cnt_reg >= 12'h4dd && rdy_cnt_reg <= 12'h4e7)
    else $error("ready delay off");

  cover property (mode == MODE_FAILSAFE);
  cover property (mode == MODE_FAULT);
  cover property ($rose(func_ready));
endmodule // switch_ctl_sva

bind switch_channel_mode_control switch_ctl_sva i_switch_ctl_sva (
  .ref_clk, .rst_n, .reset_n_input, .dir_in, .fault_a, .fault_b, .vdd_ok, .chip_select_n,
  .spi_sclk, .spi_so, .spi_so_oe, .failsafe_flag_n, .failsafe_flag_n_oe, .switch_output_a,
  .switch_output_b, .mode, .normal_mode_flag, .func_ready
);
`default_nettype wire

//--- switch_host_model.sv
// host controller model driving the 16-bit serial port
`timescale 1ns/1ps
`default_nettype none
module switch_host_model (
  input  wire logic ref_clk,
  input  wire logic so_pin,
  output var logic  chip_select_n,
  output var logic  spi_sclk,
  output var logic  spi_si
);
  initial begin
    chip_select_n = 1'b1;
    spi_sclk      = 1'b0; // clock stands low between frames
    spi_si        = 1'b0; // released line rests at its pull-down
  end

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  // msb first; clock levels held four cycles so edge detection never misses
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    tk(1);
    chip_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tk(4);
      spi_sclk = 1'b1;
      spi_si   = w[i]; // held past the falling edge, which is where the device takes it
      tk(4);
      spi_sclk = 1'b0;
      r[i] = so_pin;
    end
    tk(4);
    chip_select_n = 1'b1;
    spi_si = 1'b0;
    tk(4);
  endtask
endmodule // switch_host_model
`default_nettype wire
